//--- core/lfc_pkg.sv
package lfc_pkg;
  // Register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [7:0] OFS_SERIES_RES = 8'h43;
  localparam logic [7:0] OFS_FIRST_CAP = 8'h44;
  localparam logic [7:0] OFS_SHUNT_MODE = 8'h45;
  localparam logic [7:0] OFS_THIRD_CAP = 8'h46;
  // Field widths
  localparam int SER_W = 6;
  localparam int C1_W = 3;
  localparam int SHUNT_W = 6;
  localparam int C3_W = 3;
  // Field positions inside their registers
  localparam int SER_LSB = 0;
  localparam int C1_LSB = 0;
  localparam int SHUNT_LSB = 1;
  localparam int MODE_BIT = 0;
  localparam int C3_LSB = 0;
  // Reset values
  localparam logic [5:0] SER_RST = 6'h24;
  localparam logic [2:0] C1_RST = 3'h0;
  localparam logic [5:0] SHUNT_RST = 6'h00;
  localparam logic [0:0] MODE_RST = 1'h0;
  localparam logic [2:0] C3_RST = 3'h0;
  // Capacitance arithmetic in picofarads
  localparam int C1_PF_W = 9;
  localparam int C3_PF_W = 6;
  localparam logic [8:0] C1_BASE_PF = 9'h005;
  localparam logic [8:0] C1_STEP_PF = 9'h032;
  localparam logic [5:0] C3_STEP_PF = 6'h05;
  // Nonvolatile image: defined fields only, packed low to high
  localparam int NVM_W = 19;
  localparam int NVM_SER_LSB = 0;
  localparam int NVM_C1_LSB = 6;
  localparam int NVM_SHUNT_LSB = 9;
  localparam int NVM_MODE_BIT = 15;
  localparam int NVM_C3_LSB = 16;
  // Nonvolatile transfer states
  typedef enum logic [2:0]
  {
    NVM_IDLE = 3'b001,
    NVM_RECALL = 3'b010,
    NVM_STORE = 3'b100
  } lfc_nvm_e;
endpackage

//--- core/lfc_field.sv
`timescale 1ns/1ps
`default_nettype none
module lfc_field #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Host write
  input wire logic wr_en_in,
  input wire logic [W-1:0] wr_data_in,
  // Nonvolatile recall
  input wire logic ld_en_in,
  input wire logic [W-1:0] ld_data_in,
  // Stored value
  output logic [W-1:0] q_out
);
  logic [W-1:0] q_r; // Field storage
  logic [W-1:0] q_nxt; // Next field value

  // Host write wins over a recall in the same cycle
  always_comb
  begin
    q_nxt = q_r;
    if (wr_en_in)
    begin
      q_nxt = wr_data_in;
    end
    else if (ld_en_in)
    begin
      q_nxt = ld_data_in;
    end
  end

  // Synchronous active-low reset to the field default
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      q_r <= RST;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign q_out = q_r;
endmodule
`default_nettype wire

//--- core/lfc_pll1_filter_regs.sv
`timescale 1ns/1ps
`default_nettype none
module lfc_pll1_filter_regs (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic [lfc_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [lfc_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [lfc_pkg::DATA_W-1:0] reg_rdata_out,
  // Nonvolatile storage transfer
  input wire logic nvm_recall_in,
  input wire logic nvm_store_in,
  input wire logic [lfc_pkg::NVM_W-1:0] nvm_image_in,
  output logic [lfc_pkg::NVM_W-1:0] nvm_image_out,
  output logic nvm_done_out,
  // Loop filter control codes
  output logic [lfc_pkg::SER_W-1:0] series_resistor_code_out,
  output logic [lfc_pkg::C1_W-1:0] first_capacitor_code_out,
  output logic [lfc_pkg::SHUNT_W-1:0] shunt_resistor_code_out,
  output logic filter_fractional_select_out,
  output logic [lfc_pkg::C3_W-1:0] third_capacitor_code_out,
  // Decoded capacitances in picofarads
  output logic [lfc_pkg::C1_PF_W-1:0] first_capacitor_pf_out,
  output logic [lfc_pkg::C3_PF_W-1:0] third_capacitor_pf_out,
  // Pulse after any filter setting changes
  output logic filter_changed_out
);
  import lfc_pkg::*;

  // Register write strobes per address
  logic wr_ser; // Series resistor register written
  logic wr_c1; // First capacitor register written
  logic wr_shunt; // Shunt resistor and mode register written
  logic wr_c3; // Third capacitor register written

  // Current field values from storage
  logic [SER_W-1:0] ser_q; // Series resistor code
  logic [C1_W-1:0] c1_q; // First capacitor code
  logic [SHUNT_W-1:0] shunt_q; // Shunt resistor code
  logic [0:0] mode_q; // Integer or fractional select
  logic [C3_W-1:0] c3_q; // Third capacitor code

  // Recall strobe into all fields
  logic recall_ld; // High while recall state loads fields

  // Transfer sequencer
  lfc_nvm_e nvm_state_r; // Current transfer state
  lfc_nvm_e nvm_state_nxt; // Next transfer state
  logic [NVM_W-1:0] nvm_image_r; // Image handed to storage
  logic [NVM_W-1:0] nvm_image_nxt; // Next image
  logic nvm_done_r; // Transfer complete pulse
  logic nvm_done_nxt; // Next complete pulse

  // Read path
  logic [DATA_W-1:0] rdata_r; // Read data, valid one cycle after strobe
  logic [DATA_W-1:0] rdata_nxt; // Next read data

  // Output stage
  logic [C1_PF_W-1:0] c1_pf_r; // First capacitance
  logic [C1_PF_W-1:0] c1_pf_nxt; // Next first capacitance
  logic [C3_PF_W-1:0] c3_pf_r; // Third capacitance
  logic [C3_PF_W-1:0] c3_pf_nxt; // Next third capacitance
  logic [NVM_W-1:0] last_cfg_r; // Settings seen one cycle ago
  logic [NVM_W-1:0] cur_cfg; // Settings now, packed
  logic changed_r; // Settings changed pulse
  logic changed_nxt; // Next changed pulse

  // Address decode; reserved bits of a write are simply dropped
  always_comb
  begin
    wr_ser = reg_wr_in && (reg_addr_in == OFS_SERIES_RES);
    wr_c1 = reg_wr_in && (reg_addr_in == OFS_FIRST_CAP);
    wr_shunt = reg_wr_in && (reg_addr_in == OFS_SHUNT_MODE);
    wr_c3 = reg_wr_in && (reg_addr_in == OFS_THIRD_CAP);
  end

  // Recall loads every field during the recall state
  assign recall_ld = (nvm_state_r == NVM_RECALL);

  // Series resistor code, any value a valid selection
  lfc_field #(
    .W(SER_W),
    .RST(SER_RST)
  ) u_ser (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .wr_en_in(wr_ser),
    .wr_data_in(reg_wdata_in[SER_LSB +: SER_W]),
    .ld_en_in(recall_ld),
    .ld_data_in(nvm_image_in[NVM_SER_LSB +: SER_W]),
    .q_out(ser_q)
  );

  // First capacitor code
  lfc_field #(
    .W(C1_W),
    .RST(C1_RST)
  ) u_c1 (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .wr_en_in(wr_c1),
    .wr_data_in(reg_wdata_in[C1_LSB +: C1_W]),
    .ld_en_in(recall_ld),
    .ld_data_in(nvm_image_in[NVM_C1_LSB +: C1_W]),
    .q_out(c1_q)
  );

  // Shunt resistor code in bits 6:1 above the mode bit, any value valid
  lfc_field #(
    .W(SHUNT_W),
    .RST(SHUNT_RST)
  ) u_shunt (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .wr_en_in(wr_shunt),
    .wr_data_in(reg_wdata_in[SHUNT_LSB +: SHUNT_W]),
    .ld_en_in(recall_ld),
    .ld_data_in(nvm_image_in[NVM_SHUNT_LSB +: SHUNT_W]),
    .q_out(shunt_q)
  );

  // Filter mode bit shares the shunt register
  lfc_field #(
    .W(1),
    .RST(MODE_RST)
  ) u_mode (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .wr_en_in(wr_shunt),
    .wr_data_in(reg_wdata_in[MODE_BIT +: 1]),
    .ld_en_in(recall_ld),
    .ld_data_in(nvm_image_in[NVM_MODE_BIT +: 1]),
    .q_out(mode_q)
  );

  // Third capacitor code
  lfc_field #(
    .W(C3_W),
    .RST(C3_RST)
  ) u_c3 (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .wr_en_in(wr_c3),
    .wr_data_in(reg_wdata_in[C3_LSB +: C3_W]),
    .ld_en_in(recall_ld),
    .ld_data_in(nvm_image_in[NVM_C3_LSB +: C3_W]),
    .q_out(c3_q)
  );

  // Pack the defined fields only; reserved bits never reach storage
  always_comb
  begin
    cur_cfg = '0;
    cur_cfg[NVM_SER_LSB +: SER_W] = ser_q;
    cur_cfg[NVM_C1_LSB +: C1_W] = c1_q;
    cur_cfg[NVM_SHUNT_LSB +: SHUNT_W] = shunt_q;
    cur_cfg[NVM_MODE_BIT] = mode_q[0];
    cur_cfg[NVM_C3_LSB +: C3_W] = c3_q;
  end

  // Read mux; reserved and unmapped bits return zero
  always_comb
  begin
    rdata_nxt = '0;
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        OFS_SERIES_RES:
        begin
          rdata_nxt[SER_LSB +: SER_W] = ser_q;
        end
        OFS_FIRST_CAP:
        begin
          rdata_nxt[C1_LSB +: C1_W] = c1_q;
        end
        OFS_SHUNT_MODE:
        begin
          rdata_nxt[SHUNT_LSB +: SHUNT_W] = shunt_q;
          rdata_nxt[MODE_BIT] = mode_q[0];
        end
        OFS_THIRD_CAP:
        begin
          rdata_nxt[C3_LSB +: C3_W] = c3_q;
        end
        default:
        begin
          rdata_nxt = '0; // Unmapped address
        end
      endcase
    end
  end

  // Read data register
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      rdata_r <= '0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  // Transfer sequencer; recall wins if both requests arrive together
  always_comb
  begin
    nvm_state_nxt = nvm_state_r;
    nvm_image_nxt = nvm_image_r;
    nvm_done_nxt = 1'b0;
    unique case (nvm_state_r)
      NVM_IDLE:
      begin
        if (nvm_recall_in)
        begin
          nvm_state_nxt = NVM_RECALL;
        end
        else if (nvm_store_in)
        begin
          nvm_state_nxt = NVM_STORE;
        end
      end
      NVM_RECALL:
      begin
        // Fields load this cycle
        nvm_done_nxt = 1'b1;
        nvm_state_nxt = NVM_IDLE;
      end
      NVM_STORE:
      begin
        // Snapshot the defined fields for storage
        nvm_image_nxt = cur_cfg;
        nvm_done_nxt = 1'b1;
        nvm_state_nxt = NVM_IDLE;
      end
      default:
      begin
        nvm_state_nxt = NVM_IDLE; // Recover from an illegal code
      end
    endcase
  end

  // Transfer sequencer registers
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      nvm_state_r <= NVM_IDLE;
      nvm_image_r <= '0;
      nvm_done_r <= 1'b0;
    end
    else
    begin
      nvm_state_r <= nvm_state_nxt;
      nvm_image_r <= nvm_image_nxt;
      nvm_done_r <= nvm_done_nxt;
    end
  end

  // Capacitance decode and change detect
  always_comb
  begin
    c1_pf_nxt = C1_BASE_PF + (C1_PF_W'(c1_q) * C1_STEP_PF);
    c3_pf_nxt = C3_PF_W'(c3_q) * C3_STEP_PF;
    changed_nxt = (cur_cfg != last_cfg_r);
  end

  // Output stage registers
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      c1_pf_r <= C1_BASE_PF;
      c3_pf_r <= '0;
      last_cfg_r <= {C3_RST, MODE_RST, SHUNT_RST, C1_RST, SER_RST};
      changed_r <= 1'b0;
    end
    else
    begin
      c1_pf_r <= c1_pf_nxt;
      c3_pf_r <= c3_pf_nxt;
      last_cfg_r <= cur_cfg;
      changed_r <= changed_nxt;
    end
  end

  // Outputs, each straight from a flip-flop
  assign reg_rdata_out = rdata_r;
  assign nvm_image_out = nvm_image_r;
  assign nvm_done_out = nvm_done_r;
  assign series_resistor_code_out = ser_q;
  assign first_capacitor_code_out = c1_q;
  assign shunt_resistor_code_out = shunt_q;
  assign filter_fractional_select_out = mode_q[0];
  assign third_capacitor_code_out = c3_q;
  assign first_capacitor_pf_out = c1_pf_r;
  assign third_capacitor_pf_out = c3_pf_r;
  assign filter_changed_out = changed_r;
endmodule
`default_nettype wire

//--- tb/lfc_regs_chk_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lfc_regs_chk
  import lfc_pkg::*;
(
  // Clock, reset and register port
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // Nonvolatile transfer
  input wire logic nvm_recall_in,
  input wire logic nvm_store_in,
  input wire logic [18:0] nvm_image_in,
  input wire logic [18:0] nvm_image_out,
  input wire logic nvm_done_out,
  // Filter codes and capacitances
  input wire logic [5:0] series_resistor_code_out,
  input wire logic [2:0] first_capacitor_code_out,
  input wire logic [5:0] shunt_resistor_code_out,
  input wire logic filter_fractional_select_out,
  input wire logic [2:0] third_capacitor_code_out,
  input wire logic [8:0] first_capacitor_pf_out,
  input wire logic [5:0] third_capacitor_pf_out,
  // Change pulse
  input wire logic filter_changed_out
);
  // All defined fields in image order
  wire logic [18:0] fields = {third_capacitor_code_out, filter_fractional_select_out,
    shunt_resistor_code_out, first_capacitor_code_out, series_resistor_code_out};
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // Write or read strobe toward one offset
  sequence s_wr(ofs);
    reg_wr_in && reg_addr_in == ofs;
  endsequence
  sequence s_rd(ofs);
    reg_rd_in && reg_addr_in == ofs;
  endsequence
  // Transfer request made from idle
  sequence s_req(req);
    req && !$past(nvm_store_in) && !$past(nvm_recall_in);
  endsequence
  AST_RESET_DEFAULTS: assert property (
    rst_b_in && !$past(rst_b_in) |-> fields == {C3_RST, MODE_RST, SHUNT_RST, C1_RST, SER_RST})
    else $error("codes not at defaults after reset");
  AST_SERIES_WRITE: assert property (
    s_wr(OFS_SERIES_RES) |=> series_resistor_code_out == $past(reg_wdata_in[5:0]))
    else $error("series code write lost");
  AST_FIRST_CAP_WRITE: assert property (
    s_wr(OFS_FIRST_CAP) |=> first_capacitor_code_out == $past(reg_wdata_in[2:0]))
    else $error("first capacitor write lost");
  AST_SHUNT_MODE_WRITE: assert property (
    s_wr(OFS_SHUNT_MODE) |=> {shunt_resistor_code_out, filter_fractional_select_out}
      == $past(reg_wdata_in[6:0]))
    else $error("shunt or mode write lost");
  AST_THIRD_CAP_WRITE: assert property (
    s_wr(OFS_THIRD_CAP) |=> third_capacitor_code_out == $past(reg_wdata_in[2:0]))
    else $error("third capacitor write lost");
  AST_FIRST_CAP_PF: assert property (
    $past(rst_b_in) |-> first_capacitor_pf_out
      == C1_BASE_PF + C1_STEP_PF * $past(first_capacitor_code_out))
    else $error("first capacitance wrong");
  AST_THIRD_CAP_PF: assert property (
    $past(rst_b_in) |-> third_capacitor_pf_out == C3_STEP_PF * $past(third_capacitor_code_out))
    else $error("third capacitance wrong");
  AST_READ_SERIES: assert property (
    s_rd(OFS_SERIES_RES) |=> reg_rdata_out == {2'b00, $past(series_resistor_code_out)})
    else $error("series read wrong");
  AST_READ_SHUNT: assert property (
    s_rd(OFS_SHUNT_MODE) |=> reg_rdata_out
      == {1'b0, $past(shunt_resistor_code_out), $past(filter_fractional_select_out)})
    else $error("shunt read wrong");
  AST_READ_UNMAPPED: assert property (
    reg_rd_in && !(reg_addr_in inside {[8'h43:8'h46]}) |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  AST_STORE_IMAGE: assert property (
    s_req(nvm_store_in && !nvm_recall_in) |-> ##2 nvm_done_out && nvm_image_out == $past(fields))
    else $error("store image wrong");
  AST_RECALL_LOAD: assert property (
    s_req(nvm_recall_in) |-> ##2 nvm_done_out && fields == $past(nvm_image_in))
    else $error("recall load wrong");
  // Change pulse follows a field difference between the two previous cycles
  AST_CHANGED_PULSE: assert property (
    $past(rst_b_in) && $past(rst_b_in, 2) |-> filter_changed_out
      == ($past(fields) != $past(fields, 2)))
    else $error("change pulse wrong");
endmodule
`default_nettype wire

//--- tb/lfc_pll1_filter_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lfc_pll1_filter_regs_tb;
  // Design ports
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, nvm_recall_in = 1'b0, nvm_store_in = 1'b0;
  logic [18:0] nvm_image_in = 19'h00000, nvm_image_out;
  logic nvm_done_out, filter_fractional_select_out, filter_changed_out;
  logic [5:0] series_resistor_code_out, shunt_resistor_code_out, third_capacitor_pf_out;
  logic [2:0] first_capacitor_code_out, third_capacitor_code_out;
  logic [8:0] first_capacitor_pf_out;
  // Model fields, expectations and counters
  int ser_m, c1_m, sh_m, md_m, c3_m, c1pf_e, c3pf_e, rd_q, mismatches, checks_done;
  int seed = 35574;
  logic rd_d = 1'b0, mon_on = 1'b0;
  logic ch_e = 1'b0; // Expected change pulse
  logic [18:0] img_p = 19'h00000; // Model image one edge ago
  // Listed resistor codes
  logic [7:0] ser_t [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h30};
  logic [7:0] sh_t [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
  lfc_pll1_filter_regs i_lfc_pll1_filter_regs (.*);
  always #5 sys_clk_in = ~sys_clk_in;
  // Model image of the defined fields
  function automatic logic [18:0] img_m();
    return 19'(c3_m * 65536 + md_m * 32768 + sh_m * 512 + c1_m * 64 + ser_m);
  endfunction
  // Model read value; reserved bits and unmapped places are zero
  function automatic int rd_exp(input logic [7:0] a);
    case (a)
      8'h43: return ser_m;
      8'h44: return c1_m;
      8'h45: return sh_m * 2 + md_m;
      8'h46: return c3_m;
      default: return 0;
    endcase
  endfunction
  // Compare one design value against the model
  task automatic cmp(input logic [18:0] got, input logic [18:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Register write, strobe left high for back-to-back use
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_in <= 1'b1;
    reg_rd_in <= 1'b0;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    case (a)
      8'h43: ser_m <= d[5:0];
      8'h44: c1_m <= d[2:0];
      8'h45:
      begin
        sh_m <= d[6:1];
        md_m <= d[0];
      end
      8'h46: c3_m <= d[2:0];
      default: ;
    endcase
  endtask
  // Register read; data checked by the monitor
  task automatic rd(input logic [7:0] a);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
  endtask
  // Store or recall; done checked in the answer cycle, and the image too after a store
  task automatic xfer(input logic rec, input logic [18:0] img);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    nvm_recall_in <= rec;
    nvm_store_in <= !rec;
    nvm_image_in <= img;
    @(posedge sys_clk_in);
    nvm_recall_in <= 1'b0;
    nvm_store_in <= 1'b0;
    @(posedge sys_clk_in);
    if (rec)
    begin
      ser_m <= img[5:0];
      c1_m <= img[8:6];
      sh_m <= img[14:9];
      md_m <= img[15];
      c3_m <= img[18:16];
    end
    nvm_image_in <= ~img;
    @(negedge sys_clk_in);
    cmp(nvm_done_out, 19'h00001);
    if (!rec)
      cmp(nvm_image_out, img_m());
    @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    cmp(nvm_done_out, 19'h00000);
    @(posedge sys_clk_in);
  endtask
  // Synchronous reset, model back to defaults
  task automatic do_reset(input int n);
    mon_on <= 1'b0;
    rst_b_in <= 1'b0;
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    ser_m <= 'h24;
    {c1_m, sh_m, md_m, c3_m} <= '0;
    repeat (n) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    @(posedge sys_clk_in);
    mon_on <= 1'b1;
  endtask
  // Read, capacitance and change expectations taken at the edge
  always @(posedge sys_clk_in)
  begin
    rd_d <= reg_rd_in;
    rd_q <= rd_exp(reg_addr_in);
    c1pf_e <= 5 + 50 * c1_m;
    c3pf_e <= 5 * c3_m;
    ch_e <= (img_m() != img_p);
    img_p <= img_m();
  end
  // Compare read data, field codes, capacitances and change pulse mid-cycle
  always @(negedge sys_clk_in)
    if (mon_on)
    begin
      cmp(reg_rdata_out, rd_d ? rd_q : 0);
      cmp({third_capacitor_code_out, filter_fractional_select_out, shunt_resistor_code_out,
        first_capacitor_code_out, series_resistor_code_out}, img_m());
      cmp({first_capacitor_pf_out, third_capacitor_pf_out}, c1pf_e * 64 + c3pf_e);
      cmp(19'(filter_changed_out), 19'(ch_e));
    end
  // Counts, verdict and end of run
  task automatic close_out();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Cuts a hung run short
  initial
  begin
    #50us;
    mismatches++;
    close_out();
  end
  // Test sequence
  initial
  begin
    do_reset(8);
    for (int i = 'h42; i <= 'h47; i++)
      rd(8'(i));
    $display("test reset_values done");
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h43, 8'hC0 | ser_t[i % 6]);
      wr(8'h44, 8'hF8 | 8'(i));
      wr(8'h45, 8'h80 | sh_t[i % 6] | 8'(i % 2));
      wr(8'h46, 8'hF8 | 8'(7 - i));
      for (int a = 'h43; a <= 'h46; a++)
        rd(8'(a));
    end
    $display("test code_tables done");
    repeat (300)
      if ($random(seed) & 1)
        wr(8'h40 + 8'($random(seed) & 7), 8'($random(seed)));
      else
        rd(8'h40 + 8'($random(seed) & 7));
    $display("test random_traffic done");
    xfer(1'b0, 19'h00000);
    xfer(1'b1, 19'($random(seed)));
    xfer(1'b0, 19'h00000);
    $display("test nonvolatile done");
    wr(8'h43, 8'h3F);
    do_reset(2);
    rd(8'h43);
    rd(8'h45);
    reg_rd_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    $display("test mid_reset done");
    close_out();
  end
endmodule
bind lfc_pll1_filter_regs lfc_regs_chk i_lfc_regs_chk (.*);
`default_nettype wire
